// >>> pdl_regs.v
// Purpose: Device control low byte and read-only link capabilities register logic
// Assumes: Configuration requests arrive from the upstream link logic on ref_clk
// Notes:   Error detectors and message senders live outside; this block gates them
`include "pdl_regs.vh"

module pdl_regs
(
   input  wire        ref_clk,
   input  wire        nrst,
   input  wire        cfg_req,
   input  wire        cfg_wr,
   input  wire [11:0] cfg_addr,
   input  wire [3:0]  cfg_be,
   input  wire [31:0] cfg_wdata,
   output reg  [31:0] cfg_rdata,
   output reg         cfg_ack,
   input  wire        ur_detect,
   input  wire        fatal_detect,
   input  wire        nonfatal_detect,
   input  wire        cor_detect,
   input  wire        msg_path_enable,
   output wire        ur_report,
   output wire        fatal_msg_send,
   output wire        nonfatal_msg_send,
   output wire        cor_msg_send,
   output reg  [9:0]  payload_limit_bytes
);

////////////////////////////////////////////////////////////////////////////////

   reg  [2:0] payload_limit_code;
   reg        loose_ordering_enable;
   reg        unsupported_request_report_enable;
   reg        fatal_report_enable;
   reg        nonfatal_report_enable;
   reg        correctable_report_enable;
   wire       link_active_report_capable;
   wire       surprise_down_report_capable;
   wire [7:0]  port_number;
   wire [2:0]  cap_reserved;
   wire [2:0]  standby_exit_latency;
   wire [2:0]  deep_sleep_exit_latency;
   wire        refclk_removal_capable;
   wire [1:0]  power_state_support;
   wire [5:0]  max_link_width;
   wire [3:0]  max_link_speed;
   wire [31:0] link_cap_value;
   wire [7:0]  dev_ctl_low;
   wire        wr_ctl;

   // Offset compare used by the write decode; the read decode uses its own case
   function offset_hit;
      input [11:0] addr;
      input [11:0] offset;
      begin
         offset_hit = (addr == offset);
      end
   endfunction

   function [9:0] payload_bytes;
      input [2:0] code;
      begin
         case (code)
            `PDL_PAYLOAD_128: payload_bytes = `PDL_BYTES_128;
            `PDL_PAYLOAD_256: payload_bytes = `PDL_BYTES_256;
            default:          payload_bytes = `PDL_BYTES_512;
         endcase
      end
   endfunction

////////////////////////////////////////////////////////////////////////////////

   // Constant image built field by field; no storage so writes cannot alter it
   assign port_number                  = `PDL_CAP_PORT_VALUE;
   assign cap_reserved                 = `PDL_CAP_RSVD_VALUE;
   assign link_active_report_capable   = `PDL_CAP_FLAG_VALUE;
   assign surprise_down_report_capable = `PDL_CAP_FLAG_VALUE;
   assign refclk_removal_capable       = `PDL_CAP_FLAG_VALUE;
   assign deep_sleep_exit_latency      = `PDL_CAP_DEEP_EXIT_VALUE;
   assign standby_exit_latency         = `PDL_CAP_STBY_EXIT_VALUE;
   assign power_state_support          = `PDL_CAP_PWR_SUP_VALUE;
   assign max_link_width               = `PDL_CAP_WIDTH_VALUE;
   assign max_link_speed               = `PDL_CAP_SPEED_VALUE;

   // Whole word is wired constants, so a write has nothing to change
   assign link_cap_value[`PDL_CAP_PORT_POS+7:`PDL_CAP_PORT_POS]           = port_number;
   assign link_cap_value[`PDL_CAP_RSVD_POS+2:`PDL_CAP_RSVD_POS]           = cap_reserved;
   assign link_cap_value[`PDL_CAP_LINK_ACT_POS]                           = link_active_report_capable;
   assign link_cap_value[`PDL_CAP_SURPRISE_POS]                           = surprise_down_report_capable;
   assign link_cap_value[`PDL_CAP_REFCLK_POS]                             = refclk_removal_capable;
   assign link_cap_value[`PDL_CAP_DEEP_EXIT_POS+2:`PDL_CAP_DEEP_EXIT_POS] = deep_sleep_exit_latency;
   assign link_cap_value[`PDL_CAP_STBY_EXIT_POS+2:`PDL_CAP_STBY_EXIT_POS] = standby_exit_latency;
   assign link_cap_value[`PDL_CAP_PWR_SUP_POS+1:`PDL_CAP_PWR_SUP_POS]     = power_state_support;
   assign link_cap_value[`PDL_CAP_WIDTH_POS+5:`PDL_CAP_WIDTH_POS]         = max_link_width;
   assign link_cap_value[`PDL_CAP_SPEED_POS+3:`PDL_CAP_SPEED_POS]         = max_link_speed;

   assign dev_ctl_low = {payload_limit_code, loose_ordering_enable,
                         unsupported_request_report_enable, fatal_report_enable,
                         nonfatal_report_enable, correctable_report_enable};

   // Only lane 0 carries the control byte; other lanes never touch it
   assign wr_ctl = cfg_req && cfg_wr && offset_hit(cfg_addr, `PDL_DEV_CTL_OFFSET) && cfg_be[0];

   // Every code is stored as written; software keeps it in range
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         payload_limit_code <= `PDL_PAYLOAD_RESET;
      end
      else if (wr_ctl)
      begin
         payload_limit_code <= cfg_wdata[`PDL_PAYLOAD_POS+2:`PDL_PAYLOAD_POS];
      end
   end

   // Stored for readback only
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         loose_ordering_enable <= `PDL_LOOSE_ORDER_RESET;
      end
      else if (wr_ctl)
      begin
         loose_ordering_enable <= cfg_wdata[`PDL_LOOSE_ORDER_POS];
      end
   end

   // Unsupported request reporting
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         unsupported_request_report_enable <= `PDL_ERR_EN_RESET;
      end
      else if (wr_ctl)
      begin
         unsupported_request_report_enable <= cfg_wdata[`PDL_UR_EN_POS];
      end
   end

   // Fatal message enable
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         fatal_report_enable <= `PDL_ERR_EN_RESET;
      end
      else if (wr_ctl)
      begin
         fatal_report_enable <= cfg_wdata[`PDL_FATAL_EN_POS];
      end
   end

   // Nonfatal message enable
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         nonfatal_report_enable <= `PDL_ERR_EN_RESET;
      end
      else if (wr_ctl)
      begin
         nonfatal_report_enable <= cfg_wdata[`PDL_NONFATAL_EN_POS];
      end
   end

   // Correctable message enable
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         correctable_report_enable <= `PDL_ERR_EN_RESET;
      end
      else if (wr_ctl)
      begin
         correctable_report_enable <= cfg_wdata[`PDL_COR_EN_POS];
      end
   end

   // Read data registered; one-cycle ack for every request
   always @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cfg_rdata           <= `PDL_RDATA_RESET;
         cfg_ack             <= 1'h0;
         payload_limit_bytes <= `PDL_BYTES_128;
      end
      else
      begin
         cfg_ack             <= cfg_req;
         payload_limit_bytes <= payload_bytes(payload_limit_code);
         if (cfg_req && !cfg_wr)
         begin
            case (cfg_addr)
               `PDL_LINK_CAP_OFFSET: cfg_rdata <= link_cap_value;
               `PDL_DEV_CTL_OFFSET:  cfg_rdata <= {24'h000000, dev_ctl_low};
               default:              cfg_rdata <= 32'h00000000;
            endcase
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////

   // Ordering enable is stored only; relaxed ordering is never used
   assign ur_report         = ur_detect && unsupported_request_report_enable;
   assign fatal_msg_send    = fatal_detect && fatal_report_enable && msg_path_enable;
   assign nonfatal_msg_send = nonfatal_detect && nonfatal_report_enable && msg_path_enable;
   assign cor_msg_send      = cor_detect && correctable_report_enable && msg_path_enable;

endmodule // pdl_regs

// >>> pdl_regs.vh
// Purpose: Constants for the device control low byte and link capabilities registers
// Assumes: 32-bit configuration dword access, byte enables per lane
// Notes:   Offsets are byte addresses in configuration space
`ifndef PDL_REGS_VH
`define PDL_REGS_VH

`define PDL_LINK_CAP_OFFSET      12'h0cc
`define PDL_DEV_CTL_OFFSET       12'h0c8
`define PDL_LINK_CAP_RESET       32'h00003441
`define PDL_PAYLOAD_POS          5
`define PDL_PAYLOAD_RESET        3'h0
`define PDL_LOOSE_ORDER_POS      4
`define PDL_LOOSE_ORDER_RESET    1'h1
`define PDL_UR_EN_POS            3
`define PDL_FATAL_EN_POS         2
`define PDL_NONFATAL_EN_POS      1
`define PDL_COR_EN_POS           0
`define PDL_PAYLOAD_128          3'h0
`define PDL_PAYLOAD_256          3'h1
`define PDL_BYTES_128            10'h080
`define PDL_BYTES_256            10'h100
`define PDL_BYTES_512            10'h200
`define PDL_ERR_EN_RESET         1'h0
`define PDL_RDATA_RESET          32'h00000000
`define PDL_CAP_PORT_POS         24
`define PDL_CAP_PORT_VALUE       8'h00
`define PDL_CAP_RSVD_POS         21
`define PDL_CAP_RSVD_VALUE       3'h0
`define PDL_CAP_LINK_ACT_POS     20
`define PDL_CAP_SURPRISE_POS     19
`define PDL_CAP_REFCLK_POS       18
`define PDL_CAP_FLAG_VALUE       1'h0
`define PDL_CAP_DEEP_EXIT_POS    15
`define PDL_CAP_DEEP_EXIT_VALUE  3'h0
`define PDL_CAP_STBY_EXIT_POS    12
`define PDL_CAP_STBY_EXIT_VALUE  3'h3
`define PDL_CAP_PWR_SUP_POS      10
`define PDL_CAP_PWR_SUP_VALUE    2'h1
`define PDL_CAP_WIDTH_POS        4
`define PDL_CAP_WIDTH_VALUE      6'h04
`define PDL_CAP_SPEED_POS        0
`define PDL_CAP_SPEED_VALUE      4'h1

`endif

// >>> pdl_chk.sv
// Purpose: Port assertions for pdl_regs
// Assumes: One clock, synchronous low reset
// Notes: Bound from the bench top
module pdl_chk (input wire ref_clk, nrst, cfg_req, cfg_wr, cfg_ack, ur_detect, ur_report, fatal_detect,
   input wire msg_path_enable, fatal_msg_send, cor_detect, cor_msg_send, nonfatal_detect, nonfatal_msg_send,
   input wire [11:0] cfg_addr, input wire [31:0] cfg_rdata, input wire [9:0] payload_limit_bytes);
   timeunit 1ns; timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   ack_follows_a: assert property (cfg_req |=> cfg_ack) else $error("no ack");
   ack_caused_a: assert property (cfg_ack |-> $past(cfg_req)) else $error("stray ack");
   cap_value_a: assert property (cfg_req && !cfg_wr && cfg_addr == 12'h0cc |=> cfg_rdata == 32'h00003441)
      else $error("cap value");
   ur_gate_a: assert property (ur_report |-> ur_detect) else $error("ur gate");
   fatal_gate_a: assert property (fatal_msg_send |-> fatal_detect && msg_path_enable) else $error("fatal gate");
   cor_gate_a: assert property (cor_msg_send |-> cor_detect && msg_path_enable) else $error("cor gate");
   nonfatal_gate_a: assert property (nonfatal_msg_send |-> nonfatal_detect && msg_path_enable)
      else $error("nonfatal gate");
   size_set_a: assert property (payload_limit_bytes inside {10'h080, 10'h100, 10'h200}) else $error("size");
   size_reset_a: assert property ($rose(nrst) |-> payload_limit_bytes == 10'h080) else $error("size reset");
endmodule // pdl_chk

// >>> pdl_host.sv
// Purpose: Upstream configuration requester
// Assumes: One-cycle request pulse, answer on the next edge
// Notes: Released lines show inverted data so stale values fail
module pdl_host (input wire ref_clk, input wire cfg_ack, input wire [31:0] cfg_rdata, output logic cfg_req = 0,
   output logic cfg_wr = 0,
   output logic [11:0] cfg_addr = 0, output logic [3:0] cfg_be = 0, output logic [31:0] cfg_wdata = 0);
   timeunit 1ns; timeprecision 1ps;
   task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
      output logic [31:0] q, output logic k);
      @(posedge ref_clk);
      cfg_req <= 1; cfg_wr <= w; cfg_addr <= a; cfg_be <= b; cfg_wdata <= d;
      @(posedge ref_clk);
      cfg_req <= 0; cfg_addr <= ~a; cfg_be <= ~b; cfg_wdata <= ~d;
      // Answer taken at the edge where ack is sampled high
      @(posedge ref_clk);
      k = cfg_ack;
      q = cfg_rdata;
   endtask
endmodule // pdl_host

// >>> pdl_regs_tb.sv
// Purpose: Self-checking bench for pdl_regs
// Assumes: Error detect inputs driven here
// Notes: Watchdog ends a hung run
module pdl_regs_tb;
   timeunit 1ns; timeprecision 1ps;
   logic ref_clk = 0, nrst = 0, msg_path_enable = 0, cfg_req, cfg_wr, cfg_ack;
   logic [3:0] det = 0, cfg_be;
   logic [11:0] cfg_addr;
   logic [31:0] cfg_wdata, cfg_rdata, q;
   logic ack;
   wire [3:0] rep;
   wire [9:0] pl;
   int miscompares = 0, check_count = 0;
   initial forever #12.5 ref_clk = ~ref_clk;
   pdl_host pdl_host_i (.ref_clk, .cfg_ack, .cfg_rdata, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata);
   pdl_regs pdl_regs_i (.ref_clk, .nrst, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
      .ur_detect(det[3]), .fatal_detect(det[2]), .nonfatal_detect(det[1]), .cor_detect(det[0]), .msg_path_enable,
      .ur_report(rep[3]), .fatal_msg_send(rep[2]), .nonfatal_msg_send(rep[1]), .cor_msg_send(rep[0]),
      .payload_limit_bytes(pl));
   task t(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      pdl_host_i.xfer(w, a, b, d, q, ack);
      chk(ack, 1);
   endtask
   task chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin miscompares++; $display("Error at %0t: seen %h expected %h", $time, s, e); end
   endtask
   task tally_and_finish;
      if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task reset_values;
      t(0, 12'h0c8, 4'h1, 0); chk(q[7:0], 8'h10);
      t(1, 12'h0cc, 4'hf, '1); t(0, 12'h0cc, 4'hf, 0); chk(q, 32'h00003441);
      t(0, 12'h0d0, 4'hf, 0); chk(q, 0);
   endtask
   task payload_codes;
      for (int c = 0; c < 8; c++) begin
         t(1, 12'h0c8, 4'h1, c << 5);
         @(negedge ref_clk); chk(pl, c == 0 ? 10'h080 : c == 1 ? 10'h100 : 10'h200);
         t(0, 12'h0c8, 4'h1, 0); chk(q[7:0], c << 5);
      end
      t(1, 12'h0c8, 4'h0, 32'h1f); t(0, 12'h0c8, 4'h1, 0); chk(q[7:0], 8'he0);
   endtask
   task error_gates;
      logic [3:0] en;
      for (int k = 0; k < 4; k++) begin
         en = k[1] ? 4'ha : 4'h5;
         t(1, 12'h0c8, 4'h1, en);
         @(posedge ref_clk); det <= 4'hf; msg_path_enable <= k[0];
         @(negedge ref_clk); chk(rep, en & {1'b1, {3{k[0]}}});
      end
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      nrst <= 1;
      reset_values; payload_codes; error_gates;
      tally_and_finish;
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      miscompares++; tally_and_finish;
   end
endmodule // pdl_regs_tb
bind pdl_regs pdl_chk pdl_chk_i (.ref_clk, .nrst, .cfg_req, .cfg_wr, .cfg_ack, .ur_detect, .ur_report, .fatal_detect,
   .msg_path_enable, .fatal_msg_send, .cor_detect, .cor_msg_send, .nonfatal_detect, .nonfatal_msg_send, .cfg_addr,
   .cfg_rdata, .payload_limit_bytes);
